// [core/vfd_display_end.sv]
// Contract
// R01 - bytes travel least significant bit first
// R02 - sample serial input on clock rising edge
// R03 - select line at chip select fall types frame
// R04 - host waits 400 ns between frames
// R05 - host spaces data bytes 600 ns apart
// R06 - write command stores following data bytes
// R07 - read command ignores input, returns display bytes
// R08 - first read byte is dummy, discarded
// R09 - host spaces read bytes 1 us apart
// R10 - frame interrupt pulse 65 us every 8.4 ms
// R11 - host scrolls only during active interrupt pulse
// R12 - host sends display mode command first
// R13 - mode data byte selects gray scale or not
// R14 - address set lower byte first, then upper
// R15 - serial port active only with select grounded
// R16 - output bits change on falling clock edge
module vfd_display_end #(
	parameter int ram_aw         = 12,
	parameter int int_period_cyc = vfd_pkg::int_period_cyc,
	parameter int int_pulse_cyc  = vfd_pkg::int_pulse_cyc
) (
	input  wire logic              i_clock,
	input  wire logic              i_resetn,
	vfd_link_if.display_mp         link,
	output logic [7:0]             o_rx_byte,
	output logic                   o_rx_valid,
	output logic                   o_rx_is_cmd,
	output logic [ram_aw-1:0]      o_addr,
	output logic [7:0]             o_mode,
	output logic                   o_mode_valid,
	output logic                   o_gray_scale,
	output logic [11:0]            o_start1,
	output logic [11:0]            o_start2
);

	localparam int icw = $clog2(int_period_cyc + 1);

	generate
		if (ram_aw < 9 || ram_aw > 12) begin : g_bad_aw
			$error("ram_aw must lie between 9 and 12");
		end
		if (int_pulse_cyc < 1 || int_pulse_cyc >= int_period_cyc) begin : g_bad_int
			$error("interrupt pulse must be shorter than its period");
		end
	endgenerate

	// ----------------------------------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [4:0]        sync1_q;
	logic [4:0]        sync2_q;
	logic              sclk_prev_q;
	logic              csn_prev_q;
	logic              s_sclk;
	logic              s_csn;
	logic              s_cd;
	logic              s_si;
	logic              s_seln;
	logic              rise;
	logic              fall;
	logic              cs_fall;
	logic              active;

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			sync1_q     <= vfd_pkg::link_idle;
			sync2_q     <= vfd_pkg::link_idle;
			sclk_prev_q <= 1'b1;
			csn_prev_q  <= 1'b1;
		end else begin
			sync1_q     <= {link.sel_n, link.si, link.cd, link.cs_n, link.sclk};
			sync2_q     <= sync1_q;
			sclk_prev_q <= s_sclk;
			csn_prev_q  <= s_csn;
		end
	end

	assign s_sclk  = sync2_q[vfd_pkg::sync_sclk];
	assign s_csn   = sync2_q[vfd_pkg::sync_csn];
	assign s_cd    = sync2_q[vfd_pkg::sync_cd];
	assign s_si    = sync2_q[vfd_pkg::sync_si];
	assign s_seln  = sync2_q[vfd_pkg::sync_seln];
	assign rise    = s_sclk & ~sclk_prev_q;
	assign fall    = ~s_sclk & sclk_prev_q;
	assign cs_fall = ~s_csn & csn_prev_q & ~s_seln; // R15
	assign active  = ~s_csn & ~s_seln; // R15

	// ----------------------------------------------------------------
	// frame type
	// ----------------------------------------------------------------
	logic              cmd_frame_q;
	logic              rd_frame_q;
	logic [7:0]        cmd_q;

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			cmd_frame_q <= 1'b0;
			rd_frame_q  <= 1'b0;
		end else if (cs_fall) begin
			cmd_frame_q <= s_cd; // R03
			rd_frame_q  <= ~s_cd & (cmd_q == vfd_pkg::cmd_read); // R07
		end else if (s_csn) begin
			rd_frame_q  <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// receive shifter
	// ----------------------------------------------------------------
	logic [2:0]        bit_cnt_q;
	logic [7:0]        in_sh_q;
	logic [7:0]        byte_in;
	logic              byte_stb;
	logic              data_stb;

	assign byte_in  = {s_si, in_sh_q[7:1]}; // R01
	assign byte_stb = active & rise & (bit_cnt_q == 3'h7) & ~rd_frame_q; // R07
	assign data_stb = byte_stb & ~cmd_frame_q;

	always_ff @(posedge i_clock) begin
		if (!i_resetn || cs_fall) begin
			bit_cnt_q <= 3'h0;
			in_sh_q   <= 8'h00;
		end else if (active && rise) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			in_sh_q   <= byte_in; // R02
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			cmd_q <= 8'h00;
		end else if (byte_stb && cmd_frame_q) begin
			cmd_q <= byte_in;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			o_rx_byte   <= 8'h00;
			o_rx_valid  <= 1'b0;
			o_rx_is_cmd <= 1'b0;
		end else begin
			o_rx_valid <= byte_stb;
			if (byte_stb) begin
				o_rx_byte   <= byte_in;
				o_rx_is_cmd <= cmd_frame_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// settings carried by data frames
	// ----------------------------------------------------------------
	logic [1:0]        int_mode_q;

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			o_mode       <= 8'h00;
			o_mode_valid <= 1'b0;
			int_mode_q   <= vfd_pkg::int_mode_pos;
			o_start1     <= 12'h000;
			o_start2     <= 12'h000;
		end else if (data_stb) begin
			case (cmd_q)
				vfd_pkg::cmd_mode: begin
					o_mode       <= byte_in; // R13
					o_mode_valid <= 1'b1;
				end
				vfd_pkg::cmd_int_mode:  int_mode_q     <= byte_in[1:0];
				vfd_pkg::cmd_start1_lo: o_start1[7:0]  <= byte_in;
				vfd_pkg::cmd_start1_hi: o_start1[11:8] <= byte_in[3:0];
				vfd_pkg::cmd_start2_lo: o_start2[7:0]  <= byte_in;
				vfd_pkg::cmd_start2_hi: o_start2[11:8] <= byte_in[3:0];
				default: ;
			endcase
		end
	end

	assign o_gray_scale = o_mode[vfd_pkg::mode_gray_bit]; // R13

	// ----------------------------------------------------------------
	// display memory and its address
	// ----------------------------------------------------------------
	logic [7:0]        ram_q [2**ram_aw];
	logic              fetch_stb;
	logic              byte_done_q;

	assign fetch_stb = rd_frame_q & active & fall & byte_done_q;

	// one pointer serves writes and reads; it wraps at the top of memory
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			o_addr <= '0;
		end else if (data_stb) begin
			case (cmd_q)
				vfd_pkg::cmd_write:   o_addr <= o_addr + 1'b1; // R06
				vfd_pkg::cmd_addr_lo: o_addr[7:0] <= byte_in; // R14
				vfd_pkg::cmd_addr_hi: o_addr[ram_aw-1:8] <= byte_in[ram_aw-9:0]; // R14
				default: ;
			endcase
		end else if (fetch_stb) begin
			o_addr <= o_addr + 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (data_stb && cmd_q == vfd_pkg::cmd_write) begin
			ram_q[o_addr] <= byte_in; // R06
		end
	end

	// ----------------------------------------------------------------
	// read-back shifter
	// ----------------------------------------------------------------
	// the first fall of a frame already shifts, so the dummy is loaded one
	// place up and its bit 0 reaches the pin before the first rise
	logic [7:0]        out_sh_q;

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			out_sh_q    <= 8'h00;
			byte_done_q <= 1'b0;
		end else if (cs_fall) begin
			out_sh_q    <= {vfd_pkg::dummy_byte[6:0], 1'b0}; // R08
			byte_done_q <= 1'b0;
		end else if (!rd_frame_q || s_csn) begin
			out_sh_q    <= 8'h00;
			byte_done_q <= 1'b0;
		end else if (active) begin
			if (rise && bit_cnt_q == 3'h7) begin
				byte_done_q <= 1'b1;
			end
			if (fall) begin
				if (byte_done_q) begin
					out_sh_q    <= ram_q[o_addr]; // R08
					byte_done_q <= 1'b0;
				end else begin
					out_sh_q <= {1'b0, out_sh_q[7:1]}; // R16
				end
			end
		end
	end

	assign link.so = out_sh_q[0]; // R16

	// ----------------------------------------------------------------
	// frame interrupt
	// ----------------------------------------------------------------
	logic [icw-1:0]    int_cnt_q;
	logic              irq_q;
	logic              pulse;

	assign pulse = int_cnt_q < icw'(int_pulse_cyc); // R10

	always_ff @(posedge i_clock) begin
		if (!i_resetn || int_cnt_q == icw'(int_period_cyc - 1)) begin
			int_cnt_q <= '0;
		end else begin
			int_cnt_q <= int_cnt_q + 1'b1; // R10
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			irq_q <= 1'b0;
		end else begin
			case (int_mode_q)
				vfd_pkg::int_mode_pos: irq_q <= pulse; // R11
				vfd_pkg::int_mode_neg: irq_q <= ~pulse; // R11
				default:               irq_q <= 1'b0;
			endcase
		end
	end

	assign link.irq = irq_q;

endmodule // vfd_display_end

// [core/vfd_pkg.sv]
package vfd_pkg;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] cmd_write     = 8'h08;
	localparam logic [7:0] cmd_read      = 8'h09;
	localparam logic [7:0] cmd_start1_lo = 8'h0a;
	localparam logic [7:0] cmd_start1_hi = 8'h0b;
	localparam logic [7:0] cmd_start2_lo = 8'h0c;
	localparam logic [7:0] cmd_start2_hi = 8'h0d;
	localparam logic [7:0] cmd_addr_lo   = 8'h0e;
	localparam logic [7:0] cmd_addr_hi   = 8'h0f;
	localparam logic [7:0] cmd_mode      = 8'h14;
	localparam logic [7:0] cmd_int_mode  = 8'h15;

	// ----------------------------------------------------------------
	// field layouts and reset values
	// ----------------------------------------------------------------
	localparam int         mode_gray_bit  = 2;
	localparam logic [1:0] int_mode_off   = 2'h0;
	localparam logic [1:0] int_mode_pos   = 2'h1;
	localparam logic [1:0] int_mode_neg   = 2'h3;
	localparam logic [7:0] dummy_byte     = 8'h00;
	localparam int         sync_sclk      = 0;
	localparam int         sync_csn       = 1;
	localparam int         sync_cd        = 2;
	localparam int         sync_si        = 3;
	localparam int         sync_seln      = 4;
	localparam logic [4:0] link_idle      = 5'h13;
	localparam int         entry_last_bit = 8;
	localparam int         entry_cd_bit   = 9;
	localparam int         entry_rd_bit   = 10;
	localparam int         entry_w        = 11;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int clk_period_ns  = 25;
	localparam int cs_gap_ns      = 400;
	localparam int byte_gap_ns    = 600;
	localparam int read_gap_ns    = 1000;
	localparam int int_pulse_us   = 65;
	localparam int int_period_us  = 8400;
	localparam int cs_gap_cyc     = (cs_gap_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int byte_gap_cyc   = (byte_gap_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int read_gap_cyc   = (read_gap_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int int_pulse_cyc  = (int_pulse_us * 1000) / clk_period_ns;
	localparam int int_period_cyc = (int_period_us * 1000) / clk_period_ns;
	localparam int sclk_half_cyc  = 8;

endpackage

// [core/vfd_link_if.sv]
interface vfd_link_if;
	logic sclk;
	logic cs_n;
	logic cd;
	logic si;
	logic so;
	logic irq;
	logic sel_n;

	modport display_mp (
		input  sclk,
		input  cs_n,
		input  cd,
		input  si,
		input  sel_n,
		output so,
		output irq
	);

	modport host_mp (
		output sclk,
		output cs_n,
		output cd,
		output si,
		output sel_n,
		input  so,
		input  irq
	);
endinterface

// [core/vfd_host_end.sv]
module vfd_host_end #(
	parameter int width    = vfd_pkg::entry_w,
	parameter int depth    = 2,
	parameter int half_cyc = vfd_pkg::sclk_half_cyc
) (
	input  wire logic             i_clock,
	input  wire logic             i_resetn,
	vfd_link_if.host_mp           link,
	input  wire logic             i_valid,
	input  wire logic [width-1:0] i_entry,
	output logic                  o_ready,
	output logic [7:0]            o_rx_byte,
	output logic                  o_rx_valid,
	output logic                  o_busy,
	output logic                  o_frame_int
);

	localparam int pw = (depth > 1) ? $clog2(depth) : 1;
	localparam int cw = $clog2(depth + 1);

	generate
		if (width != vfd_pkg::entry_w || depth < 2 || half_cyc < 8 || half_cyc > 255) begin : g_bad
			$error("host end needs entry width, depth of two or more and half period 8 to 255");
		end
	endgenerate

	// ----------------------------------------------------------------
	// entry buffer
	// ----------------------------------------------------------------
	logic [width-1:0] mem_q [depth];
	logic [pw-1:0]    wr_ptr_q;
	logic [pw-1:0]    rd_ptr_q;
	logic [cw-1:0]    count_q;
	logic             push;
	logic             pop;
	logic             f_valid;
	logic [width-1:0] head;

	assign o_ready = count_q != cw'(depth);
	assign f_valid = count_q != '0;
	assign push    = i_valid & o_ready;
	assign head    = mem_q[rd_ptr_q];

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_entry;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == pw'(depth - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == pw'(depth - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			count_q <= count_q + cw'(push) - cw'(pop);
		end
	end

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] so_q;
	logic [1:0] irq_q;

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			so_q  <= 2'h0;
			irq_q <= 2'h0;
		end else begin
			so_q  <= {so_q[0], link.so};
			irq_q <= {irq_q[0], link.irq};
		end
	end

	assign o_frame_int = irq_q[1];

	// ----------------------------------------------------------------
	// link sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {st_idle, st_lead, st_shift, st_gap, st_end} state_e;

	state_e           state_q;
	logic [7:0]       timer_q;
	logic [3:0]       phase_q;
	logic [width-1:0] cur_q;
	logic [7:0]       sh_q;
	logic [7:0]       rx_q;
	logic             first_q;
	logic             sclk_q;
	logic             csn_q;
	logic             cd_q;
	logic             si_q;

	// the next byte of a frame is not taken before the gap has run out,
	// so a slow producer only stretches the gap
	assign pop = f_valid & (timer_q == 8'h00) & (state_q == st_idle || state_q == st_gap); // R05

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state_q    <= st_idle;
			timer_q    <= 8'h00;
			phase_q    <= 4'h0;
			cur_q      <= '0;
			sh_q       <= 8'h00;
			rx_q       <= 8'h00;
			first_q    <= 1'b0;
			sclk_q     <= 1'b1;
			csn_q      <= 1'b1;
			cd_q       <= 1'b0;
			si_q       <= 1'b0;
			o_rx_byte  <= 8'h00;
			o_rx_valid <= 1'b0;
		end else begin
			o_rx_valid <= 1'b0;
			if (timer_q != 8'h00) begin
				timer_q <= timer_q - 8'h01;
			end
			unique case (state_q)
				st_idle: if (pop) begin
					cur_q   <= head;
					cd_q    <= head[vfd_pkg::entry_cd_bit]; // R03
					timer_q <= 8'(half_cyc - 1);
					state_q <= st_lead;
				end
				st_lead: if (timer_q == 8'h00) begin
					csn_q   <= 1'b0;
					first_q <= 1'b1;
					sh_q    <= cur_q[7:0];
					si_q    <= cur_q[0];
					phase_q <= 4'h0;
					timer_q <= 8'(half_cyc - 1);
					state_q <= st_shift;
				end
				st_shift: if (timer_q == 8'h00) begin
					timer_q <= 8'(half_cyc - 1);
					phase_q <= phase_q + 4'h1;
					if (!phase_q[0]) begin
						sclk_q <= 1'b0;
						si_q   <= sh_q[0]; // R01
					end else begin
						sclk_q <= 1'b1;
						sh_q   <= {1'b0, sh_q[7:1]};
						rx_q   <= {so_q[1], rx_q[7:1]}; // R01
					end
					if (phase_q == 4'hf) begin
						if (cur_q[vfd_pkg::entry_rd_bit]) begin
							first_q <= 1'b0;
							if (!first_q) begin
								o_rx_byte  <= {so_q[1], rx_q[7:1]}; // R08
								o_rx_valid <= 1'b1;
							end
						end
						if (cur_q[vfd_pkg::entry_last_bit]) begin
							state_q <= st_end;
						end else begin
							state_q <= st_gap;
							timer_q <= cur_q[vfd_pkg::entry_rd_bit] ? 8'(vfd_pkg::read_gap_cyc) // R09
							                                        : 8'(vfd_pkg::byte_gap_cyc); // R05
						end
					end
				end
				st_gap: if (pop) begin
					cur_q   <= head;
					sh_q    <= head[7:0];
					phase_q <= 4'h0;
					timer_q <= 8'(half_cyc - 1);
					state_q <= st_shift;
				end
				st_end: if (timer_q == 8'h00) begin
					csn_q   <= 1'b1;
					timer_q <= 8'(vfd_pkg::cs_gap_cyc); // R04
					state_q <= st_idle;
				end
			endcase
		end
	end

	assign o_busy     = (state_q != st_idle) | ~csn_q;
	assign link.sclk  = sclk_q;
	assign link.cs_n  = csn_q;
	assign link.cd    = cd_q;
	assign link.si    = si_q;
	assign link.sel_n = 1'b0; // R15

endmodule // vfd_host_end

// [dv/vfd_link_properties.sv]
module vfd_link_properties #(
	parameter int int_period_cyc = 400,
	parameter int int_pulse_cyc  = 20
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic cd,
	input wire logic si,
	input wire logic so,
	input wire logic irq,
	input wire logic sel_n
);
	// ----------------------------------------------------------------
	// frame tracking
	// ----------------------------------------------------------------
	logic        frm_cmd_q;
	logic [2:0]  bit_q;
	logic [3:0]  byte_q;
	logic [7:0]  sh_q;
	logic [7:0]  cmd_q;
	logic [7:0]  gap_q;
	logic [31:0] hi_q;
	logic [31:0] per_q;
	logic [1:0]  nrise_q;
	logic        rd_frame;

	// read frames are only known from the last command byte seen on the wire
	assign rd_frame = !frm_cmd_q && (cmd_q == vfd_pkg::cmd_read);

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			frm_cmd_q <= 1'b0;
			bit_q     <= 3'h0;
			byte_q    <= 4'h0;
			sh_q      <= 8'h00;
			cmd_q     <= 8'h00;
		end else if ($fell(cs_n)) begin
			frm_cmd_q <= cd;
			bit_q     <= 3'h0;
			byte_q    <= 4'h0;
		end else if (!cs_n && $rose(sclk)) begin
			sh_q  <= {si, sh_q[7:1]};
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				byte_q <= byte_q + 4'h1;
				if (frm_cmd_q) begin
					cmd_q <= {si, sh_q[7:1]};
				end
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn || $rose(sclk)) begin
			gap_q <= 8'h00;
		end else if (gap_q != 8'hff) begin
			gap_q <= gap_q + 8'h01;
		end
	end

	// the first pulse after reset may be cut short, so width is judged from the second on
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			hi_q    <= 32'h0;
			per_q   <= 32'h0;
			nrise_q <= 2'h0;
		end else begin
			hi_q  <= irq ? hi_q + 32'h1 : 32'h0;
			per_q <= $rose(irq) ? 32'h1 : per_q + 32'h1;
			if ($rose(irq) && nrise_q != 2'h3) begin
				nrise_q <= nrise_q + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	sequence s_cs_quiet;
		cs_n [*8] ##1 cs_n [*8];
	endsequence

	sequence s_si_held;
		$stable(si) ##1 $stable(si);
	endsequence

	a_frame_gap_hold: assert property ($rose(cs_n) |-> s_cs_quiet)
		else $error("chip select gap too short");
	a_frame_type_hold: assert property (!cs_n |-> $stable(cd))
		else $error("frame type line moved inside a frame");
	a_si_settled: assert property (!cs_n && $rose(sclk) |-> s_si_held)
		else $error("serial input moved around a clock rise");
	a_clock_idle_high: assert property (cs_n |-> sclk)
		else $error("serial clock low outside a frame");
	a_write_byte_gap: assert property (!cs_n && !rd_frame && $fell(sclk) && bit_q == 3'h0 && byte_q != 4'h0
		|-> gap_q >= vfd_pkg::byte_gap_cyc)
		else $error("bytes sent too close together");
	a_read_byte_gap: assert property (!cs_n && rd_frame && $fell(sclk) && bit_q == 3'h0 && byte_q != 4'h0
		|-> gap_q >= vfd_pkg::read_gap_cyc)
		else $error("bytes read too close together");
	a_out_bit_held: assert property (rd_frame && !cs_n && $rose(sclk) |-> $stable(so))
		else $error("serial output moved at a clock rise");
	a_dummy_first: assert property (rd_frame && !cs_n && byte_q == 4'h0 && $rose(sclk)
		|-> so == vfd_pkg::dummy_byte[bit_q])
		else $error("first read byte is not the dummy");
	a_out_quiet: assert property (cs_n [*4] |-> !so)
		else $error("serial output driven outside a frame");
	a_serial_selected: assert property (!cs_n |-> !sel_n)
		else $error("serial port not selected during a frame");
	a_int_width: assert property ($fell(irq) && nrise_q >= 2'h2 |-> hi_q == int_pulse_cyc)
		else $error("interrupt pulse width wrong");
	a_int_period: assert property ($rose(irq) && nrise_q != 2'h0 |-> per_q == int_period_cyc)
		else $error("interrupt period wrong");
endmodule // vfd_link_properties

// [dv/tb_top.sv]
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int per_c = 400;
	localparam int pul_c = 20;
	logic        i_clock, i_resetn, i_valid, h_ready, h_rx_valid, h_busy, h_frame_int;
	logic        d_rx_valid, d_is_cmd, d_mode_valid, d_gray, saw_full;
	logic [10:0] i_entry;
	logic [7:0]  h_rx_byte, d_rx_byte, d_mode, rnd, lo, hi, nb;
	logic [11:0] d_addr, d_start1, d_start2, base;
	logic [7:0]  ram_m [0:4095];
	logic [7:0]  modes [3] = '{8'h10, 8'h14, 8'h10};
	logic [8:0]  dq[$];
	logic [7:0]  hq[$], wq[$], rq[$];
	int          error_cnt, n_compared, cyc_cnt, n;

	vfd_link_if u_vfd_link_if ();

	vfd_display_end #(.ram_aw(12), .int_period_cyc(per_c), .int_pulse_cyc(pul_c)) u_vfd_display_end (
		.i_clock(i_clock), .i_resetn(i_resetn), .link(u_vfd_link_if), .o_rx_byte(d_rx_byte),
		.o_rx_valid(d_rx_valid), .o_rx_is_cmd(d_is_cmd), .o_addr(d_addr), .o_mode(d_mode),
		.o_mode_valid(d_mode_valid), .o_gray_scale(d_gray), .o_start1(d_start1), .o_start2(d_start2));
	vfd_host_end u_vfd_host_end (
		.i_clock(i_clock), .i_resetn(i_resetn), .link(u_vfd_link_if), .i_valid(i_valid), .i_entry(i_entry),
		.o_ready(h_ready), .o_rx_byte(h_rx_byte), .o_rx_valid(h_rx_valid), .o_busy(h_busy),
		.o_frame_int(h_frame_int));
	vfd_link_properties #(.int_period_cyc(per_c), .int_pulse_cyc(pul_c)) u_props (
		.i_clock(i_clock), .i_resetn(i_resetn), .sclk(u_vfd_link_if.sclk), .cs_n(u_vfd_link_if.cs_n),
		.cd(u_vfd_link_if.cd), .si(u_vfd_link_if.si), .so(u_vfd_link_if.so), .irq(u_vfd_link_if.irq),
		.sel_n(u_vfd_link_if.sel_n));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rnd_b();
		rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
		return rnd;
	endfunction

	function automatic logic [11:0] addr_of(input logic [7:0] l, input logic [7:0] h);
		return {h[3:0], l};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// valid stays up after acceptance until the next entry or wait_idle lowers it
	task automatic push(input logic rd, input logic cd, input logic last, input logic [7:0] b);
		@(negedge i_clock);
		i_valid = 1'b1;
		i_entry = {rd, cd, last, b};
		while (h_ready !== 1'b1) @(negedge i_clock);
		@(posedge i_clock);
	endtask

	task automatic frame(input logic cd, input logic rd, input logic [7:0] q[$]);
		foreach (q[i]) push(rd, cd, i == q.size() - 1, q[i]);
	endtask

	task automatic cmd2(input logic [7:0] code, input logic [7:0] val);
		frame(1'b1, 1'b0, '{code});
		frame(1'b0, 1'b0, '{val});
	endtask

	// busy drops between the frames of a pair while the next entry sits out
	// the chip select gap, so idle must last longer than that gap
	task automatic wait_idle();
		int k, run;
		k = 0;
		run = 0;
		@(negedge i_clock);
		i_valid = 1'b0;
		while (run < 32 && k < 3000) begin
			k++;
			run = (h_busy === 1'b0) ? run + 1 : 0;
			@(negedge i_clock);
		end
		check("host idle", k < 3000, 1'b1);
	endtask

	// ----------------------------------------------------------------
	// clock, monitors, timeout
	// ----------------------------------------------------------------
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	always @(posedge i_clock) begin
		if (d_rx_valid === 1'b1) dq.push_back({d_is_cmd, d_rx_byte});
		if (h_rx_valid === 1'b1) hq.push_back(h_rx_byte);
		if (i_valid === 1'b1 && h_ready === 1'b0) saw_full = 1'b1;
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		i_resetn = 1'b0;
		i_valid = 1'b0;
		i_entry = 11'h000;
		saw_full = 1'b0;
		rnd = 8'h31;
		repeat (5) @(negedge i_clock);
		i_resetn = 1'b1;
		@(negedge i_clock);
		check("mode valid at reset", d_mode_valid, 1'b0);
		check("clock idle", u_vfd_link_if.sclk & u_vfd_link_if.cs_n, 1'b1);
		foreach (modes[i]) begin
			cmd2(vfd_pkg::cmd_mode, modes[i]);
			wait_idle();
			check("mode", d_mode, modes[i]);
			check("mode valid", d_mode_valid, 1'b1);
			check("gray", d_gray, modes[i][vfd_pkg::mode_gray_bit]);
		end
		for (int k = 0; k < 2; k++) begin
			lo = rnd_b();
			hi = rnd_b();
			wait (h_frame_int === 1'b0);
			wait (h_frame_int === 1'b1);
			cmd2(8'(vfd_pkg::cmd_start1_lo + 2 * k), lo);
			cmd2(8'(vfd_pkg::cmd_start1_hi + 2 * k), hi);
			wait_idle();
			check("start", k == 0 ? d_start1 : d_start2, addr_of(lo, hi));
		end
		for (int r = 0; r < 4; r++) begin
			lo = r == 0 ? 8'hff : rnd_b();
			hi = r == 0 ? 8'h0f : rnd_b();
			base = addr_of(lo, hi);
			nb = rnd_b();
			n = 1 + nb[1:0];
			cmd2(vfd_pkg::cmd_addr_lo, lo);
			cmd2(vfd_pkg::cmd_addr_hi, hi);
			wait_idle();
			check("address", d_addr, base);
			wq.delete();
			for (int i = 0; i < n; i++) begin
				wq.push_back(rnd_b());
				ram_m[12'(base + i)] = wq[i];
			end
			dq.delete();
			frame(1'b1, 1'b0, '{vfd_pkg::cmd_write});
			frame(1'b0, 1'b0, wq);
			wait_idle();
			check("rx count", dq.size(), n + 1);
			check("cmd byte", dq[0], {1'b1, vfd_pkg::cmd_write});
			for (int i = 0; i < n; i++) check("data byte", dq[i + 1], {1'b0, wq[i]});
			check("address after write", d_addr, 12'(base + n));
			cmd2(vfd_pkg::cmd_addr_lo, lo);
			cmd2(vfd_pkg::cmd_addr_hi, hi);
			rq.delete();
			for (int i = 0; i <= n; i++) rq.push_back(rnd_b());
			hq.delete();
			frame(1'b1, 1'b0, '{vfd_pkg::cmd_read});
			frame(1'b0, 1'b1, rq);
			wait_idle();
			check("read count", hq.size(), n);
			for (int i = 0; i < n; i++) check("read byte", hq[i], ram_m[12'(base + i)]);
		end
		check("buffer refused", saw_full, 1'b1);
		n = 0;
		lo = 8'h00;
		hi[0] = h_frame_int;
		repeat (2 * per_c) begin
			@(negedge i_clock);
			if (h_frame_int === 1'b1 && hi[0] === 1'b0) n++;
			if (h_frame_int === 1'b1) lo++;
			hi[0] = h_frame_int;
		end
		check("int pulses", n, 2);
		check("int high cycles", lo, 2 * pul_c);
		print_verdict();
	end
endmodule // tb_top
